/* File: hlw_watchdog.sv */
`timescale 1ns/1ps
// Purpose: Host link watchdog, relay arbitration and link configuration
// Assumes: Keepalive and clear commands arrive as one-cycle pulses from the
//          protocol engine or as register writes; i_power_cycle marks a restart
// Notes:   Stored settings survive i_power_cycle but not i_reset_n
//          The timer counts only while running, so no stale
//          count survives a disable; pins and writes share commands
//
// Function
// - Factory settings are address 1, Modbus RTU, 9600, N81, zero delay.
// - Enabled watchdog without keepalive in time flags timeout, relay to safe.
// - After timeout host relay writes are ignored until clear command or restart.
// - With alarm enabled and linked, timeout does not force relay; relay follows alarm.
// - Alarm enabled and linked switches relay on when alarm is active.
// - Strap on at power-up forces ASCII, address 0, 9600, N81, no checksum.
// - Protocol and checksum change only in a strap power-up.
// - New link settings apply only after strap off and power cycle.
// - Under Modbus RTU, address, baud and parity change without strap.
module hlw_watchdog #(
	parameter int unsigned P_STEP_CYCLES = hlw_pkg::STEP_CYCLES
) (
	input  wire logic               i_mclk,
	input  wire logic               i_reset_n,
	input  wire logic               i_psel,
	input  wire logic               i_penable,
	input  wire logic               i_pwrite,
	input  wire logic [31:0]        i_paddr,
	input  wire logic [31:0]        i_pwdata,
	output logic [31:0]             o_prdata,
	output logic                    o_pready,
	output logic                    o_pslverr,
	input  wire logic               i_init_strap,
	input  wire logic               i_power_cycle,
	input  wire logic               i_keepalive,
	input  wire logic               i_clear_timeout_command,
	input  wire logic               i_alarm,
	output logic                    o_relay,
	output logic                    o_timeout,
	output logic                    o_irq,
	output hlw_pkg::hlw_cfg_s       o_link_cfg,
	output logic [7:0]              o_resp_delay
);
	import hlw_pkg::*;

	// Decoded accesses; the core answers hit
	hlw_reg_if regs ();

	// ==========================================================
	// Bus slave
	hlw_apb u_apb (
		.i_mclk    (i_mclk),
		.i_reset_n (i_reset_n),
		.i_psel    (i_psel),
		.i_penable (i_penable),
		.i_pwrite  (i_pwrite),
		.i_paddr   (i_paddr),
		.i_pwdata  (i_pwdata),
		.o_prdata  (o_prdata),
		.o_pready  (o_pready),
		.o_pslverr (o_pslverr),
		.regs      (regs)
	);

	// Write strobe per register
	// Only a mapped access raises wr, so a
	// refused write never reaches a register
	function automatic logic wr_to(input logic [7:0] ofs);
		return regs.wr && (regs.addr == ofs);
	endfunction

	// ==========================================================
	// Registers and internal state
	// A restart clears ctrl and state, loads host bit from power-on bit;
	// limit, mask and stored settings survive
	logic [2:0]       ctrl;
	logic [7:0]       timeout_steps;
	logic [2:0]       relay_reg;
	hlw_cfg_s         stored;
	logic [7:0]       stored_delay;
	logic             strap_session;
	logic             boot_pending;
	logic [EV_W-1:0]  irq_stat;
	logic [EV_W-1:0]  irq_mask;
	logic [EV_W-1:0]  events;
	logic             alarm_q;
	logic             keepalive;
	logic             clear_cmd;
	logic             expire;
	logic [7:0]       steps;
	logic             alarm_owns;
	logic             wdt_en;
	hlw_state_e       state;
	hlw_state_e       next_state;
	hlw_cfg_s         next_stored;
	logic             cfg_refused;

	// Pin and register commands are ORed; both
	// only restart or release, so no arbitration
	assign wdt_en     = ctrl[CTRL_WDT_EN];
	assign alarm_owns = ctrl[CTRL_ALARM_EN] & ctrl[CTRL_ALARM_LINK];
	assign keepalive  = i_keepalive | (wr_to(OFS_COMMAND) & regs.wdata[CMD_KEEPALIVE]);
	assign clear_cmd  = i_clear_timeout_command | (wr_to(OFS_COMMAND) & regs.wdata[CMD_CLEAR]);

	// ==========================================================
	// Host link timer
	// Expiry is a one-cycle pulse
	hlw_timer #(
		.P_STEP_CYCLES (P_STEP_CYCLES)
	) u_timer (
		.i_mclk    (i_mclk),
		.i_reset_n (i_reset_n),
		.i_enable  (state == HLW_RUN),
		.i_restart (keepalive),
		.i_limit   (timeout_steps),
		.o_expire  (expire),
		.o_steps   (steps)
	);

	// ==========================================================
	// Watchdog state machine
	always_comb begin
		next_state = state;
		case (state)
			HLW_IDLE: begin
				// Timer held at zero until enabled
				if (wdt_en) begin
					next_state = HLW_RUN;
				end
			end
			HLW_RUN: begin
				// A keepalive in the expiry cycle wins
				if (!wdt_en) begin
					next_state = HLW_IDLE;
				end else if (expire && !keepalive) begin
					next_state = HLW_EXPIRED;
				end
			end
			HLW_EXPIRED: begin
				// Besides a reset or restart, only the clear command leaves the latched timeout
				if (clear_cmd) begin
					next_state = wdt_en ? HLW_RUN : HLW_IDLE;
				end
			end
			default: begin
				// Illegal codes go idle, not expired
				next_state = HLW_IDLE;
			end
		endcase
	end

	// A restart drops a latched timeout; the
	// host enables the watchdog after each boot
	always_ff @(posedge i_mclk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			state <= HLW_IDLE;
		end else if (i_power_cycle) begin
			state <= HLW_IDLE;
		end else begin
			state <= next_state;
		end
	end

	assign o_timeout = (state == HLW_EXPIRED);

	// ==========================================================
	// Control registers; a power cycle returns only ctrl to its reset value
	// Only enables clear, so a restart cannot
	// force the relay safe before the host is back
	always_ff @(posedge i_mclk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			ctrl          <= CTRL_RESET;
			timeout_steps <= TIMEOUT_RESET;
			irq_mask      <= MASK_RESET;
		end else if (i_power_cycle) begin
			ctrl          <= CTRL_RESET;
		end else begin
			if (wr_to(OFS_CTRL)) begin
				ctrl <= regs.wdata[2:0];
			end
			if (wr_to(OFS_TIMEOUT)) begin
				timeout_steps <= regs.wdata[7:0];
			end
			if (wr_to(OFS_IRQ_MASK)) begin
				irq_mask <= regs.wdata[EV_W-1:0];
			end
		end
	end

	// Relay register: host bit is locked while the timeout is latched
	// Safe and power-on bits stay writable so
	// the host can prepare them before the clear
	always_ff @(posedge i_mclk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			relay_reg <= RELAY_RESET;
		end else if (i_power_cycle) begin
			relay_reg[RELAY_HOST] <= relay_reg[RELAY_POWER_ON];
		end else if (wr_to(OFS_RELAY)) begin
			relay_reg[RELAY_POWER_ON] <= regs.wdata[RELAY_POWER_ON];
			relay_reg[RELAY_SAFE]     <= regs.wdata[RELAY_SAFE];
			if (state != HLW_EXPIRED) begin
				relay_reg[RELAY_HOST] <= regs.wdata[RELAY_HOST];
			end
		end
	end

	// ==========================================================
	// Relay output; alarm ownership outranks the watchdog
	// Registered so the pin never glitches
	always_ff @(posedge i_mclk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			o_relay <= 1'b0;
		end else if (alarm_owns) begin
			o_relay <= i_alarm;
		end else if (state == HLW_EXPIRED) begin
			o_relay <= relay_reg[RELAY_SAFE];
		end else begin
			o_relay <= relay_reg[RELAY_HOST];
		end
	end

	// ==========================================================
	// Stored settings write filter; fields the session may not touch keep
	// their value, and the refusal is reported as an event
	// Address and delay always writable; ASCII
	// without the strap locks the other fields
	always_comb begin
		next_stored = stored;
		cfg_refused = 1'b0;
		if (wr_to(OFS_STORED)) begin
			next_stored.addr = regs.wdata[7:0];
			if (strap_session) begin
				next_stored = hlw_cfg_s'(regs.wdata[CFG_W-1:0]);
			end else if (!o_link_cfg.ascii) begin
				next_stored.baud   = regs.wdata[13:8];
				next_stored.format = regs.wdata[15:14];
				cfg_refused = (regs.wdata[17:16] != {stored.ascii, stored.checksum});
			end else begin
				cfg_refused = (regs.wdata[CFG_W-1:8] != stored[CFG_W-1:8]);
			end
		end
	end

	// Stored settings survive a power cycle, not a full reset
	always_ff @(posedge i_mclk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			stored       <= CFG_FACTORY;
			stored_delay <= DELAY_FACT;
		end else begin
			stored <= next_stored;
			if (wr_to(OFS_STORED)) begin
				stored_delay <= regs.wdata[31:24];
			end
		end
	end

	// ==========================================================
	// Boot: strap is caught on the clock after reset release or restart
	// The delay lets the strap settle; a later
	// strap change waits for the next boot
	always_ff @(posedge i_mclk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			boot_pending <= 1'b1;
		end else begin
			boot_pending <= i_power_cycle;
		end
	end

	// Active link settings change only at boot
	always_ff @(posedge i_mclk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			strap_session <= 1'b0;
			o_link_cfg    <= CFG_FACTORY;
			o_resp_delay  <= DELAY_FACT;
		end else if (boot_pending) begin
			strap_session <= i_init_strap;
			o_resp_delay  <= stored_delay;
			if (i_init_strap) begin
				o_link_cfg <= CFG_STRAP;
			end else begin
				o_link_cfg <= stored;
			end
		end
	end

	// ==========================================================
	// Interrupt status: set wins over a same-cycle write-one-to-clear
	// Alarm history resets to the idle pin
	// level, so no false edge follows reset
	always_ff @(posedge i_mclk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			alarm_q <= 1'b0;
		end else begin
			alarm_q <= i_alarm;
		end
	end

	// Timeout fires on the transition only, so a
	// cleared bit stays clear while latched
	always_comb begin
		events                 = '0;
		events[EV_TIMEOUT]     = (state == HLW_RUN) && (next_state == HLW_EXPIRED);
		events[EV_ALARM]       = i_alarm & ~alarm_q;
		events[EV_KEEPALIVE]   = keepalive;
		events[EV_CFG_REFUSED] = cfg_refused;
	end

	always_ff @(posedge i_mclk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			irq_stat <= '0;
		end else if (wr_to(OFS_IRQ_STAT)) begin
			irq_stat <= (irq_stat & ~regs.wdata[EV_W-1:0]) | events;
		end else begin
			irq_stat <= irq_stat | events;
		end
	end

	// Level output until unmasked bits clear
	assign o_irq = |(irq_stat & irq_mask);

	// ==========================================================
	// Read mux and address decode; unmapped offsets miss
	// COMMAND reads as zero: its bits are strobes
	always_comb begin
		regs.rdata = 32'h0000_0000;
		regs.hit   = 1'b1;
		case (regs.addr)
			OFS_CTRL:     regs.rdata[2:0] = ctrl;
			OFS_TIMEOUT:  regs.rdata[7:0] = timeout_steps;
			OFS_RELAY:    regs.rdata[2:0] = relay_reg;
			OFS_COMMAND:  regs.rdata = 32'h0000_0000;
			OFS_STORED:   regs.rdata = {stored_delay, 6'h00, stored};
			OFS_ACTIVE:   regs.rdata = {o_resp_delay, 6'h00, o_link_cfg};
			OFS_IRQ_STAT: regs.rdata[EV_W-1:0] = irq_stat;
			OFS_IRQ_MASK: regs.rdata[EV_W-1:0] = irq_mask;
			OFS_STATE:    regs.rdata = {16'h0000, steps, 3'h0, i_alarm,
				strap_session, o_relay, alarm_owns, o_timeout};
			default:      regs.hit = 1'b0;
		endcase
	end
endmodule // hlw_watchdog

/* File: hlw_pkg.sv */
// Purpose: Constants shared by the host link watchdog blocks
// Assumes: 10 MHz system clock, 32-bit APB register bus
// Notes:   Byte offsets, field positions, reset values and timing counts
package hlw_pkg;
	// ==========================================================
	// Timing
	localparam int unsigned CLK_PERIOD_NS  = 100;
	localparam int unsigned STEP_PERIOD_NS = 100_000_000;     // 0.1 s watchdog step
	localparam int unsigned STEP_CYCLES    = STEP_PERIOD_NS / CLK_PERIOD_NS;
	localparam int unsigned STEP_CNT_W     = 20;

	// ==========================================================
	// Register byte offsets
	localparam logic [7:0] OFS_CTRL     = 8'h00;
	localparam logic [7:0] OFS_TIMEOUT  = 8'h04;
	localparam logic [7:0] OFS_RELAY    = 8'h08;
	localparam logic [7:0] OFS_COMMAND  = 8'h0c;
	localparam logic [7:0] OFS_STORED   = 8'h10;
	localparam logic [7:0] OFS_ACTIVE   = 8'h14;
	localparam logic [7:0] OFS_IRQ_STAT = 8'h18;
	localparam logic [7:0] OFS_IRQ_MASK = 8'h1c;
	localparam logic [7:0] OFS_STATE    = 8'h20;

	// ==========================================================
	// Field positions
	localparam int unsigned CTRL_WDT_EN     = 0;
	localparam int unsigned CTRL_ALARM_EN   = 1;
	localparam int unsigned CTRL_ALARM_LINK = 2;
	localparam int unsigned RELAY_HOST      = 0;
	localparam int unsigned RELAY_SAFE      = 1;
	localparam int unsigned RELAY_POWER_ON  = 2;
	localparam int unsigned CMD_KEEPALIVE   = 0;
	localparam int unsigned CMD_CLEAR       = 1;
	localparam int unsigned EV_TIMEOUT      = 0;
	localparam int unsigned EV_ALARM        = 1;
	localparam int unsigned EV_KEEPALIVE    = 2;
	localparam int unsigned EV_CFG_REFUSED  = 3;
	localparam int unsigned EV_W            = 4;

	// ==========================================================
	// Link configuration: [7:0] address, [13:8] baud, [15:14] format,
	// [16] checksum, [17] protocol (0 Modbus RTU, 1 ASCII)
	localparam int unsigned CFG_W = 18;
	typedef struct packed {
		logic       ascii;
		logic       checksum;
		logic [1:0] format;
		logic [5:0] baud;
		logic [7:0] addr;
	} hlw_cfg_s;

	localparam logic [5:0] BAUD_9600  = 6'h06;
	localparam logic [1:0] FMT_N81    = 2'h0;
	localparam logic [7:0] ADDR_FACT  = 8'h01;
	localparam logic [7:0] ADDR_STRAP = 8'h00;
	localparam logic [7:0] DELAY_FACT = 8'h00;       // Response delay in ms
	localparam hlw_cfg_s   CFG_FACTORY = '{ascii: 1'b0, checksum: 1'b0, format: FMT_N81,
		baud: BAUD_9600, addr: ADDR_FACT};
	localparam hlw_cfg_s   CFG_STRAP   = '{ascii: 1'b1, checksum: 1'b0, format: FMT_N81,
		baud: BAUD_9600, addr: ADDR_STRAP};

	// ==========================================================
	// Reset values
	localparam logic [7:0] TIMEOUT_RESET = 8'hfa;    // 25.0 s
	localparam logic [2:0] CTRL_RESET    = 3'h0;
	localparam logic [2:0] RELAY_RESET   = 3'h0;
	localparam logic [EV_W-1:0] MASK_RESET = 4'h0;

	typedef enum logic [2:0] {
		HLW_RUN     = 3'b001,
		HLW_EXPIRED = 3'b010,
		HLW_IDLE    = 3'b100
	} hlw_state_e;
endpackage

/* File: hlw_reg_if.sv */
`timescale 1ns/1ps
// Purpose: Carries decoded register accesses from the bus slave to the core
// Assumes: One access per strobe, word index already aligned
// Notes:   hit is driven by the core's own decode
interface hlw_reg_if;
	logic [7:0]  addr;
	logic [31:0] wdata;
	logic        wr;
	logic [31:0] rdata;
	logic        hit;

	modport bus  (output addr, output wdata, output wr, input rdata, input hit);
	modport core (input addr, input wdata, input wr, output rdata, output hit);
endinterface

/* File: hlw_apb.sv */
`timescale 1ns/1ps
// Purpose: APB slave front end with no wait states
// Assumes: Master follows setup then access phase
// Notes:   Read data is captured in the setup cycle
module hlw_apb (
	input  wire logic        i_mclk,
	input  wire logic        i_reset_n,
	input  wire logic        i_psel,
	input  wire logic        i_penable,
	input  wire logic        i_pwrite,
	input  wire logic [31:0] i_paddr,
	input  wire logic [31:0] i_pwdata,
	output logic [31:0]      o_prdata,
	output logic             o_pready,
	output logic             o_pslverr,
	hlw_reg_if.bus           regs
);
	import hlw_pkg::*;

	// ==========================================================
	// Decode; unmapped addresses answer with an error, writes dropped
	assign regs.addr  = i_paddr[7:0];
	assign regs.wdata = i_pwdata;
	assign regs.wr    = i_psel & i_penable & i_pwrite & regs.hit;
	assign o_pready   = i_psel & i_penable;
	assign o_pslverr  = i_psel & i_penable & ~regs.hit;

	// Capture read data early so prdata comes from a flop
	always_ff @(posedge i_mclk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			o_prdata <= 32'h0000_0000;
		end else if (i_psel && !i_penable) begin
			o_prdata <= (!i_pwrite && regs.hit) ? regs.rdata : 32'h0000_0000;
		end
	end
endmodule // hlw_apb

/* File: hlw_timer.sv */
`timescale 1ns/1ps
// Purpose: Host link timer counting 0.1 s steps toward the timeout
// Assumes: Limit of 0 is treated as one step
// Notes:   Expiry is a single pulse; the count then holds
module hlw_timer #(
	parameter int unsigned P_STEP_CYCLES = hlw_pkg::STEP_CYCLES
) (
	input  wire logic       i_mclk,
	input  wire logic       i_reset_n,
	input  wire logic       i_enable,
	input  wire logic       i_restart,
	input  wire logic [7:0] i_limit,
	output logic            o_expire,
	output logic [7:0]      o_steps
);
	import hlw_pkg::*;

	logic [STEP_CNT_W-1:0] div;
	logic                  step;
	logic [7:0]            limit;

	assign limit = (i_limit == 8'h00) ? 8'h01 : i_limit;
	assign step  = (div == STEP_CNT_W'(P_STEP_CYCLES - 1));

	// ==========================================================
	// Step divider, restarted with the count so each step is whole
	always_ff @(posedge i_mclk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			div <= '0;
		end else if (!i_enable || i_restart || step) begin
			div <= '0;
		end else begin
			div <= div + 1'b1;
		end
	end

	// Step count; keepalive restarts it
	always_ff @(posedge i_mclk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			o_steps  <= 8'h00;
			o_expire <= 1'b0;
		end else begin
			o_expire <= 1'b0;
			if (!i_enable || i_restart) begin
				o_steps <= 8'h00;
			end else if (step && o_steps < limit) begin
				o_steps  <= o_steps + 8'h01;
				o_expire <= (o_steps + 8'h01 == limit);
			end
		end
	end
endmodule // hlw_timer

/* File: hlw_asserts.sv */
// Purpose: Port-level assertions for the host link watchdog
// Assumes: Control bits are shadowed from APB writes
// Notes:   Shadow clears on reset and on power cycle
`timescale 1ns/1ps
module hlw_asserts #(
	parameter int unsigned P_STEP_CYCLES = hlw_pkg::STEP_CYCLES
) (
	input  wire logic              i_mclk,
	input  wire logic              i_reset_n,
	input  wire logic              i_psel,
	input  wire logic              i_penable,
	input  wire logic              i_pwrite,
	input  wire logic [31:0]       i_paddr,
	input  wire logic [31:0]       i_pwdata,
	input  wire logic              i_init_strap,
	input  wire logic              i_power_cycle,
	input  wire logic              i_keepalive,
	input  wire logic              i_clear_timeout_command,
	input  wire logic              i_alarm,
	input  wire logic              o_relay,
	input  wire logic              o_timeout,
	input  wire hlw_pkg::hlw_cfg_s o_link_cfg
);
	import hlw_pkg::*;
	// ========
	// Shadow of control bits
	logic [2:0] ctrl_sh;
	logic       wr_hit;
	logic       own;
	logic       relay_wr;
	logic       clr_wr;
	assign wr_hit   = i_psel && i_penable && i_pwrite;
	assign own      = ctrl_sh[CTRL_ALARM_EN] && ctrl_sh[CTRL_ALARM_LINK];
	assign relay_wr = wr_hit && (i_paddr[7:0] == OFS_RELAY);
	assign clr_wr   = wr_hit && (i_paddr[7:0] == OFS_COMMAND) && i_pwdata[CMD_CLEAR];
	// Restart clears control, so ownership must follow it too
	always_ff @(posedge i_mclk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			ctrl_sh <= CTRL_RESET;
		end else if (i_power_cycle) begin
			ctrl_sh <= CTRL_RESET;
		end else if (wr_hit && (i_paddr[7:0] == OFS_CTRL)) begin
			ctrl_sh <= i_pwdata[2:0];
		end
	end
	// ========
	// Properties
	default clocking cb @(posedge i_mclk); endclocking
	default disable iff (!i_reset_n);
	AST_FACTORY: assert property ($rose(i_reset_n) |-> o_link_cfg == CFG_FACTORY)
		else $error("link settings not factory at boot");
	AST_STRAP: assert property ($rose(i_reset_n) && i_init_strap |=> o_link_cfg == CFG_STRAP)
		else $error("strap boot settings wrong");
	AST_NO_EARLY: assert property (i_keepalive |-> ##3 (!$rose(o_timeout)) [*6])
		else $error("timeout soon after keepalive");
	AST_HOLD: assert property (o_timeout && !i_clear_timeout_command && !clr_wr && !i_power_cycle |=> o_timeout)
		else $error("timeout dropped without clear");
	AST_CLEAR: assert property (o_timeout && (i_clear_timeout_command || clr_wr) |=> !o_timeout)
		else $error("clear did not drop timeout");
	AST_ALARM: assert property ((own [*3] ##0 $past(i_alarm) == $past(i_alarm, 2)) |-> o_relay == $past(i_alarm))
		else $error("relay not following alarm");
	AST_SAFE: assert property ((o_timeout && !own && !relay_wr && !i_power_cycle) [*3] |-> $stable(o_relay))
		else $error("relay moved while timed out");
	AST_CFG_BOOT: assert property ($changed(o_link_cfg) |->
		$past(i_power_cycle) || $past(i_power_cycle, 2) || $past(i_power_cycle, 3) || !$past(i_reset_n, 2))
		else $error("link settings changed outside boot");
endmodule // hlw_asserts

bind hlw_watchdog hlw_asserts #(.P_STEP_CYCLES(P_STEP_CYCLES)) u_asserts (.i_mclk(i_mclk), .i_reset_n(i_reset_n),
	.i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata),
	.i_init_strap(i_init_strap), .i_power_cycle(i_power_cycle), .i_keepalive(i_keepalive),
	.i_clear_timeout_command(i_clear_timeout_command), .i_alarm(i_alarm), .o_relay(o_relay),
	.o_timeout(o_timeout), .o_link_cfg(o_link_cfg));

/* File: hlw_host_model.sv */
// Purpose: Host master on the serial link, as pulses and strap
// Assumes: Changes only just after a rising edge
// Notes:   Gap of zero stops keepalives, letting the watchdog expire
`timescale 1ns/1ps
module hlw_host_model (
	input  wire logic       i_mclk,
	input  wire logic [7:0] i_gap,
	output logic            o_keepalive,
	output logic            o_clear,
	output logic            o_strap,
	output logic            o_power_cycle
);
	logic [7:0] cnt = 8'h00;
	initial begin
		o_keepalive = 1'b0;
		o_clear = 1'b0;
		o_strap = 1'b0;
		o_power_cycle = 1'b0;
	end
	// Keepalive every i_gap cycles, kept below the limit by the caller
	always @(posedge i_mclk) begin
		cnt <= (cnt + 8'h01 >= i_gap) ? 8'h00 : cnt + 8'h01;
		o_keepalive <= (i_gap != 8'h00) && (cnt == 8'h00);
	end
	// Clear-timeout command as a one-cycle pulse
	task automatic clear_cmd();
		@(posedge i_mclk);
		o_clear <= 1'b1;
		@(posedge i_mclk);
		o_clear <= 1'b0;
	endtask
	// Strap is set with the restart pulse and held after it
	task automatic restart(input logic strap);
		@(posedge i_mclk);
		o_strap <= strap;
		o_power_cycle <= 1'b1;
		@(posedge i_mclk);
		o_power_cycle <= 1'b0;
	endtask
endmodule // hlw_host_model

/* File: host_link_watchdog_config_tb.sv */
// Purpose: Self-checking bench for the host link watchdog
// Assumes: Watchdog step shortened to 10 cycles
// Notes:   Link pulses and strap come from the host model
`timescale 1ns/1ps
module host_link_watchdog_config_tb;
	import hlw_pkg::*;
	// ========
	// Signals
	localparam int unsigned STEP = 10;
	localparam hlw_cfg_s C1 = '{ascii: 1'b1, checksum: 1'b1, format: 2'h2, baud: 6'h08, addr: 8'h22};
	localparam hlw_cfg_s C2 = '{ascii: 1'b0, checksum: 1'b0, format: 2'h0, baud: 6'h08, addr: 8'h44};
	localparam hlw_cfg_s C3 = '{ascii: 1'b0, checksum: 1'b0, format: 2'h1, baud: 6'h09, addr: 8'h45};
	logic        i_mclk, i_reset_n, i_psel, i_penable, i_pwrite, i_alarm;
	logic [31:0] i_paddr, i_pwdata, o_prdata, q;
	logic        o_pready, o_pslverr, o_relay, o_timeout, o_irq, keep, clr, strap, pcyc, err;
	logic [7:0]  o_resp_delay, gap;
	hlw_cfg_s    o_link_cfg, cx;
	int          miscompares, n_tests, c;
	hlw_watchdog #(.P_STEP_CYCLES(STEP)) u_dut (.i_mclk(i_mclk), .i_reset_n(i_reset_n), .i_psel(i_psel),
		.i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_prdata(o_prdata),
		.o_pready(o_pready), .o_pslverr(o_pslverr), .i_init_strap(strap), .i_power_cycle(pcyc),
		.i_keepalive(keep), .i_clear_timeout_command(clr), .i_alarm(i_alarm), .o_relay(o_relay),
		.o_timeout(o_timeout), .o_irq(o_irq), .o_link_cfg(o_link_cfg), .o_resp_delay(o_resp_delay));
	hlw_host_model u_host (.i_mclk(i_mclk), .i_gap(gap), .o_keepalive(keep), .o_clear(clr),
		.o_strap(strap), .o_power_cycle(pcyc));
	initial begin
		i_mclk = 1'b0;
		forever #50 i_mclk = ~i_mclk;
	end
	// Hang guard
	initial begin
		repeat (100000) @(posedge i_mclk);
		miscompares++;
		conclude();
	end
	// ========
	// Tasks
	task automatic conclude();
		$display("Comparisons %0d, mismatches %0d", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			miscompares++;
			$display("ERROR %0t: got %h, expected %h", $time, got, exp);
		end
	endtask
	task automatic chk1(input logic got, input logic exp);
		chk({31'h0, got}, {31'h0, exp});
	endtask
	task automatic chkc(input hlw_cfg_s exp);
		chk({14'h0, o_link_cfg}, {14'h0, exp});
	endtask
	// Setup then access; request held until pready is seen
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge i_mclk);
		i_psel <= 1'b1;
		i_pwrite <= w;
		i_paddr <= {24'h0, a};
		i_pwdata <= d;
		@(posedge i_mclk);
		i_penable <= 1'b1;
		do begin
			@(posedge i_mclk);
			n++;
		end while (o_pready !== 1'b1 && n < 16);
		q = o_prdata;
		err = o_pslverr;
		i_psel <= 1'b0;
		i_penable <= 1'b0;
		if (n >= 16) begin
			miscompares++;
			conclude();
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		chk(q, e);
	endtask
	task automatic cyc(input int n);
		repeat (n) @(negedge i_mclk);
	endtask
	// Cycles from here until the timeout flag shows
	task automatic wait_to();
		c = 0;
		while (o_timeout !== 1'b1 && c < 400) begin
			@(negedge i_mclk);
			c++;
		end
		if (c >= 400) begin
			miscompares++;
			conclude();
		end
	endtask
	function automatic logic [31:0] st(input logic [7:0] d, input hlw_cfg_s cf);
		return {d, 6'h00, cf};
	endfunction
	// ========
	// Sequence
	initial begin
		i_reset_n = 1'b0;
		i_psel = 1'b0;
		i_penable = 1'b0;
		i_pwrite = 1'b0;
		i_paddr = 32'h0;
		i_pwdata = 32'h0;
		i_alarm = 1'b0;
		gap = 8'h00;
		repeat (20) @(posedge i_mclk);
		i_reset_n <= 1'b1;
		cyc(2);
		chkc(CFG_FACTORY);
		rd(OFS_ACTIVE, st(DELAY_FACT, CFG_FACTORY));
		rd(OFS_TIMEOUT, {24'h0, TIMEOUT_RESET});
		rd(8'h24, 32'h0);
		chk1(err, 1'b1);
		// Fast keepalives hold the timer off; then a COMMAND write keepalive restarts it
		wr(OFS_TIMEOUT, 32'h2);
		wr(OFS_RELAY, 32'h1);
		wr(OFS_IRQ_MASK, 32'h1);
		gap <= 8'h0f;
		wr(OFS_CTRL, 32'h1);
		cyc(60);
		chk1(o_timeout, 1'b0);
		gap = 8'h00;
		wr(OFS_COMMAND, 32'h1);
		wait_to();
		chk1(c >= 2 * STEP && c <= 2 * STEP + 5, 1'b1);
		cyc(2);
		chk1(o_relay, 1'b0);
		chk1(o_irq, 1'b1);
		rd(OFS_IRQ_STAT, 32'h5);
		wr(OFS_RELAY, 32'h0);
		cyc(2);
		chk1(o_relay, 1'b0);
		wr(OFS_IRQ_MASK, 32'h0);
		cyc(1);
		chk1(o_irq, 1'b0);
		wr(OFS_IRQ_STAT, 32'hf);
		wr(OFS_IRQ_MASK, 32'h1);
		cyc(1);
		chk1(o_irq, 1'b0);
		u_host.clear_cmd();
		cyc(1);
		chk1(o_timeout, 1'b0);
		wr(OFS_CTRL, 32'h0);
		rd(OFS_RELAY, 32'h1);
		cyc(2);
		chk1(o_relay, 1'b1);
		// Alarm owns the relay: timeout still flags, relay tracks alarm
		wr(OFS_TIMEOUT, 32'h1);
		wr(OFS_RELAY, 32'h6);
		wr(OFS_CTRL, 32'h7);
		wait_to();
		cyc(2);
		chk1(o_relay, 1'b0);
		@(posedge i_mclk);
		i_alarm <= ~i_alarm;
		cyc(3);
		chk1(o_relay, 1'b1);
		@(posedge i_mclk);
		i_alarm <= ~i_alarm;
		wr(OFS_COMMAND, 32'h2);
		cyc(1);
		chk1(o_timeout, 1'b0);
		wr(OFS_CTRL, 32'h0);
		// Strap boot; new settings wait for a plain boot
		u_host.restart(1'b1);
		cyc(3);
		chkc(CFG_STRAP);
		chk1(o_relay, 1'b1);
		wr(OFS_STORED, st(8'h05, C1));
		rd(OFS_STORED, st(8'h05, C1));
		chkc(CFG_STRAP);
		u_host.restart(1'b0);
		cyc(3);
		chkc(C1);
		chk1(o_resp_delay == 8'h05, 1'b1);
		// ASCII without strap: baud refused, address taken
		cx = C1;
		cx.addr = 8'h33;
		cx.baud = 6'h06;
		wr(OFS_STORED, st(8'h07, cx));
		cx.baud = 6'h08;
		rd(OFS_STORED, st(8'h07, cx));
		apb(1'b0, OFS_IRQ_STAT, 32'h0);
		chk1(q[EV_CFG_REFUSED], 1'b1);
		// Modbus without strap takes address, baud and format
		u_host.restart(1'b1);
		wr(OFS_STORED, st(8'h00, C2));
		u_host.restart(1'b0);
		cyc(3);
		chkc(C2);
		wr(OFS_STORED, st(8'h00, C3));
		rd(OFS_STORED, st(8'h00, C3));
		chkc(C2);
		u_host.restart(1'b0);
		cyc(3);
		chkc(C3);
		// Mid-run reset with the strap on
		u_host.restart(1'b1);
		@(posedge i_mclk);
		i_reset_n <= 1'b0;
		@(posedge i_mclk);
		i_reset_n <= 1'b1;
		cyc(3);
		chkc(CFG_STRAP);
		conclude();
	end
endmodule // host_link_watchdog_config_tb
